// >>> common/nadc_consts.svh
// Purpose: constants for the network ADC sampler
// Assumes: 10 MHz clock
// Notes:   timing counts derived from times in ns
`ifndef NADC_CONSTS_SVH
`define NADC_CONSTS_SVH
`define NADC_CLK_NS         100
`define NADC_SPACING_NS     26000
`define NADC_SPACING_CYC    ((`NADC_SPACING_NS) / (`NADC_CLK_NS))
`define NADC_UNIT_NS        100000
`define NADC_UNIT_CYC       ((`NADC_UNIT_NS) / (`NADC_CLK_NS))
`define NADC_IVL_MIN        14'h0002
`define NADC_IVL_MAX        14'h2710
`define NADC_IVL_RST        14'h000A
`define NADC_CNT_RST        2'h2
`define NADC_TRG_RST        1'h0
`define NADC_CUT_RST        1'h0
`define NADC_WIN_MAX        18
`define NADC_FIFO_DEPTH     8
`define NADC_CH_STRIDE      16
`define NADC_DI_LSB         12
`define NADC_POL_BIT        28
`define NADC_CUT_BIT        29
`define NADC_INV_BIT        30
`define NADC_TRG_BIT        31
`define NADC_ZERO_BIT       44
`define NADC_MODE_BIT       45
`define NADC_METHOD_LSB     46
`define NADC_SN_LSB         60
`endif

// >>> common/nadc_pkg.sv
// Purpose: types for the network ADC sampler
// Assumes: nothing
// Notes:   method codes match the strap encoding
package nadc_pkg;
   typedef enum logic [1:0] {
      M_CYCLIC = 2'b00,
      M_SINGLE = 2'b01,
      M_PERIOD = 2'b10,
      M_MOVING = 2'b11
   } nadc_method_e;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_CONV = 2'b01,
      S_WAIT = 2'b10
   } nadc_seq_e;
endpackage

// >>> hw/nadc_sampler.sv
// Purpose: sampling sequencer and result block of a 4-channel 12-bit ADC
// Assumes: all inputs synchronous to clock; adc answers one start
//          with one adc_done
// Notes on behaviour
// - each pass converts ch0..ch3 in order, about 26 us apart
// - one method governs all four channels together
// - cyclic method converts once per network cycle and publishes
// - hardware single trigger starts on selected input, as shown after inversion, falling 1 to 0
// - software trigger fires when watched byte changes to set value
// - period average collects 2/4/8/16 samples, one per interval, stores mean
// - peak cut adds two samples and drops the largest and smallest
// - defaults after reset: interval 1 ms, count 8
// - period average publishes once per complete sample set
// - moving average republishes after every interval over last set
// - averaging modes stay off network until first average exists
// - 200 us interval only with counts 2/4 (cut) or 2/4/8 (no cut)
// - 8-byte block, results at bits 11:0, 27:16, 43:32, 59:48
// - polarity bit 1 means bipolar two's complement coding
// - single trigger shows zero results and sequence 0 until trigger
// - bits 15:12 show inputs, inverted when inversion flag set
// - strap flags latched at reset shown positive, bit 44 reads 0
// - trigger-source and cut bits show the held setting
// - sequence number counts 1..15 then wraps to 1, never 0 again
// - flag bits mean setting mode, sw trigger, inversion, cut, bipolar
`timescale 1ns/1ps
`include "nadc_consts.svh"

module nadc_fifo #(
   parameter int W = 14,
   parameter int D = 8
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
   logic         push, pop;
   always_comb begin
      in_ready  = (wr_q - rd_q) != (AW+1)'(D);
      out_valid = wr_q != rd_q;
      out_data  = mem_q[rd_q[AW-1:0]];
      push      = in_valid & in_ready;
      pop       = out_valid & out_ready;
      wr_d      = push ? wr_q + 1'b1 : wr_q;
      rd_d      = pop ? rd_q + 1'b1 : rd_q;
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule

module nadc_sampler #(
   parameter int UNIT_CYCLES = `NADC_UNIT_CYC
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        method_strap_high_n,
   input  wire logic        method_strap_low_n,
   input  wire logic        setting_mode_strap_n,
   input  wire logic        inversion_strap_n,
   input  wire logic        bipolar_strap_n,
   input  wire logic [3:0]  general_input_bits,
   input  wire logic        net_cycle_pulse,
   input  wire logic        net_wr_valid,
   input  wire logic [8:0]  net_wr_addr,
   input  wire logic [7:0]  net_wr_data,
   input  wire logic        cfg_wr_valid,
   input  wire logic [13:0] cfg_interval,
   input  wire logic [1:0]  cfg_count_code,
   input  wire logic        cfg_trigger_source,
   input  wire logic        cfg_extreme_cut,
   input  wire logic [1:0]  cfg_hw_input_sel,
   input  wire logic [8:0]  cfg_watch_addr,
   input  wire logic [7:0]  cfg_watch_value,
   output logic             cfg_reject,
   output logic             adc_start,
   output logic      [1:0]  adc_channel,
   input  wire logic        adc_done,
   input  wire logic [11:0] adc_data,
   output logic             net_join,
   output logic      [63:0] memory_block
);
   import nadc_pkg::*;
   localparam logic [8:0] SPACING = 9'(`NADC_SPACING_CYC - 1);
   localparam int WIN = `NADC_WIN_MAX;

   // straps, captured on the first edge after reset release
   logic         strap_done_q;
   nadc_method_e method_q;
   logic         mode_q, inv_q, bip_q;
   // configuration held inside, changed by mail writes
   logic [13:0]  ivl_q, ivl_d;
   logic [1:0]   cnt_q, cnt_d, hsel_q, hsel_d;
   logic         trg_q, trg_d, cut_q, cut_d, rej_q, rej_d, cfg_ok;
   logic [8:0]   waddr_q, waddr_d;
   logic [7:0]   wval_q, wval_d, wprev_q, wprev_d;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         strap_done_q <= 1'b0;
         method_q     <= M_CYCLIC;
         mode_q       <= 1'b0;
         inv_q        <= 1'b0;
         bip_q        <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         method_q     <= nadc_method_e'({~method_strap_high_n,
                                         ~method_strap_low_n});
         mode_q       <= ~setting_mode_strap_n;
         inv_q        <= ~inversion_strap_n;
         bip_q        <= ~bipolar_strap_n;
      end
   end
   always_comb begin
      cfg_ok = cfg_interval >= `NADC_IVL_MIN &&
               cfg_interval <= `NADC_IVL_MAX &&
               !(cfg_interval == `NADC_IVL_MIN &&
                 (cfg_count_code == 2'h3 ||
                  (cfg_extreme_cut && cfg_count_code == 2'h2)));
      {ivl_d, cnt_d, trg_d, cut_d} = {ivl_q, cnt_q, trg_q, cut_q};
      {hsel_d, waddr_d, wval_d} = {hsel_q, waddr_q, wval_q};
      rej_d = cfg_wr_valid & ~cfg_ok;
      if (cfg_wr_valid && cfg_ok) begin
         {ivl_d, cnt_d, trg_d, cut_d} = {cfg_interval, cfg_count_code,
                                         cfg_trigger_source, cfg_extreme_cut};
         {hsel_d, waddr_d, wval_d} = {cfg_hw_input_sel, cfg_watch_addr,
                                      cfg_watch_value};
      end
      wprev_d = (net_wr_valid && net_wr_addr == waddr_q) ? net_wr_data
                                                          : wprev_q;
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ivl_q   <= `NADC_IVL_RST;
         cnt_q   <= `NADC_CNT_RST;
         trg_q   <= `NADC_TRG_RST;
         cut_q   <= `NADC_CUT_RST;
         hsel_q  <= '0;
         waddr_q <= '0;
         wval_q  <= '0;
         wprev_q <= '0;
         rej_q   <= 1'b0;
      end else begin
         {ivl_q, cnt_q, trg_q, cut_q, rej_q} <=
            {ivl_d, cnt_d, trg_d, cut_d, rej_d};
         {hsel_q, waddr_q, wval_q, wprev_q} <=
            {hsel_d, waddr_d, wval_d, wprev_d};
      end
   end
   assign cfg_reject = rej_q;

   // pass triggers
   logic        avg_mode;
   logic [3:0]  di_shown, di_prev_q;
   logic [9:0]  unit_q, unit_d;
   logic [13:0] tick_q, tick_d;
   logic        ivl_tick, hw_fall, sw_hit, pass_req;
   always_comb begin
      avg_mode = method_q[1];
      di_shown = general_input_bits ^ {4{inv_q}};
      hw_fall  = di_prev_q[hsel_q] & ~di_shown[hsel_q];
      sw_hit   = net_wr_valid && net_wr_addr == waddr_q &&
                 net_wr_data == wval_q && wprev_q != wval_q;
      ivl_tick = 1'b0;
      unit_d   = unit_q + 1'b1;
      tick_d   = tick_q;
      if (unit_q == 10'(UNIT_CYCLES - 1)) begin
         unit_d = '0;
         tick_d = tick_q + 1'b1;
         if (tick_q >= ivl_q - 1'b1) begin
            tick_d   = '0;
            ivl_tick = 1'b1;
         end
      end
      case (method_q)
         M_CYCLIC: pass_req = net_cycle_pulse;
         M_SINGLE: pass_req = trg_q ? sw_hit : hw_fall;
         default:  pass_req = ivl_tick;
      endcase
      pass_req = pass_req & strap_done_q & ~mode_q;
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         di_prev_q <= '0;
         unit_q    <= '0;
         tick_q    <= '0;
      end else begin
         di_prev_q <= di_shown;
         unit_q    <= unit_d;
         tick_q    <= tick_d;
      end
   end

   // conversion sequencer; a trigger during a pass is dropped
   nadc_seq_e   st_q, st_d;
   logic [1:0]  ch_q, ch_d;
   logic [8:0]  gap_q, gap_d;
   logic        got_q, got_d, start_d;
   logic        f_in_ready, f_out_valid, f_out_ready;
   logic [13:0] f_out_data;
   always_comb begin
      st_d = st_q;
      {ch_d, gap_d, got_d} = {ch_q, gap_q, got_q};
      start_d = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (pass_req) begin
               st_d = S_CONV;
               ch_d = 2'h0;
            end
         end
         S_CONV: begin
            // fifo room is checked before start, so a result never stalls
            if (f_in_ready) begin
               start_d = 1'b1;
               gap_d   = SPACING;
               got_d   = 1'b0;
               st_d    = S_WAIT;
            end
         end
         S_WAIT: begin
            if (adc_done) begin
               got_d = 1'b1;
            end
            if (gap_q != '0) begin
               gap_d = gap_q - 1'b1;
            end else if (got_q) begin
               st_d = (ch_q == 2'h3) ? S_IDLE : S_CONV;
               ch_d = ch_q + 1'b1;
            end
         end
         default: st_d = S_IDLE;
      endcase
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_q      <= S_IDLE;
         ch_q      <= '0;
         gap_q     <= '0;
         got_q     <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         st_q <= st_d;
         {ch_q, gap_q, got_q, adc_start} <= {ch_d, gap_d, got_d, start_d};
      end
   end
   assign adc_channel = ch_q;

   nadc_fifo #(.W(14), .D(`NADC_FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .resetn    (resetn),
      .in_valid  (adc_done),
      .in_ready  (f_in_ready),
      .in_data   ({adc_channel, adc_data}),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // sample windows and averaging
   logic [11:0] ring_q [4][WIN];
   logic [4:0]  total, kept, fill_q, fill_d, wptr_q, wptr_d;
   logic [2:0]  shift;
   logic        pend_q, pend_d, pop, cfg_hit;
   logic [11:0] avg [4];
   always_comb begin
      kept  = avg_mode ? 5'(2 << cnt_q) : 5'h01;
      // widen before adding so count code 3 gives a shift of 4, not 0
      shift = avg_mode ? 3'(cnt_q) + 3'h1 : 3'h0;
      total = kept + ((avg_mode && cut_q) ? 5'h02 : 5'h00);
      f_out_ready = ~pend_q;
      pop     = f_out_valid & f_out_ready;
      cfg_hit = cfg_wr_valid & cfg_ok;
      {fill_d, wptr_d} = {fill_q, wptr_q};
      pend_d = 1'b0;
      if (cfg_hit) begin
         {fill_d, wptr_d} = '0;
      end else if (pop && f_out_data[13:12] == 2'h3) begin
         wptr_d = (wptr_q + 1'b1 == total) ? 5'h00 : wptr_q + 1'b1;
         fill_d = (fill_q + 1'b1 >= total) ? total : fill_q + 1'b1;
         pend_d = fill_q + 1'b1 >= total;
         if (method_q == M_PERIOD && pend_d) begin
            {fill_d, wptr_d} = '0;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         fill_q <= '0;
         wptr_q <= '0;
         pend_q <= 1'b0;
      end else begin
         {fill_q, wptr_q, pend_q} <= {fill_d, wptr_d, pend_d};
      end
      if (pop) begin
         ring_q[f_out_data[13:12]][wptr_q] <= f_out_data[11:0];
      end
   end
   generate
      for (genvar c = 0; c < 4; c++) begin : g_ch
         logic signed [18:0] sum;
         logic signed [12:0] v, vmax, vmin;
         always_comb begin
            sum  = '0;
            vmax = -13'sd4096;
            vmin = 13'sd4095;
            v    = '0;
            for (int i = 0; i < WIN; i++) begin
               // bipolar values are two's complement
               v = bip_q ? 13'($signed(ring_q[c][i]))
                         : $signed({1'b0, ring_q[c][i]});
               if (5'(i) < total) begin
                  sum  = sum + 19'(v);
                  vmax = (v > vmax) ? v : vmax;
                  vmin = (v < vmin) ? v : vmin;
               end
            end
            if (avg_mode && cut_q) begin
               sum = sum - 19'(vmax) - 19'(vmin);
            end
            if (sum < 0) begin
               sum = sum + 19'(kept - 5'h01);
            end
            sum = sum >>> shift;
            avg[c] = sum[11:0];
         end
      end
   endgenerate

   // published block; results and sequence change only on publish
   logic [63:0] mb_d;
   logic [3:0]  sn_q, sn_d;
   logic        pub_q, pub_d, join_d;
   always_comb begin
      mb_d  = memory_block;
      sn_d  = sn_q;
      pub_d = pub_q | pend_q;
      if (pend_q) begin
         sn_d = (sn_q == 4'hF) ? 4'h1 : sn_q + 4'h1;
         for (int c = 0; c < 4; c++) begin
            mb_d[c*`NADC_CH_STRIDE +: 12] = avg[c];
         end
      end
      mb_d[`NADC_SN_LSB +: 4]     = sn_d;
      mb_d[`NADC_DI_LSB +: 4]     = di_shown;
      mb_d[`NADC_METHOD_LSB +: 2] = method_q;
      mb_d[`NADC_MODE_BIT]        = mode_q;
      mb_d[`NADC_ZERO_BIT]        = 1'b0;
      mb_d[`NADC_TRG_BIT]         = trg_q;
      mb_d[`NADC_INV_BIT]         = inv_q;
      mb_d[`NADC_CUT_BIT]         = cut_q;
      mb_d[`NADC_POL_BIT]         = bip_q;
      join_d = strap_done_q & (~avg_mode | pub_d);
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         memory_block <= '0;
         sn_q         <= '0;
         pub_q        <= 1'b0;
         net_join     <= 1'b0;
      end else begin
         {memory_block, sn_q, pub_q, net_join} <= {mb_d, sn_d, pub_d, join_d};
      end
   end

   // checks
   logic [9:0] since_q;
   always_ff @(posedge clock) begin
      if (!resetn || adc_start) since_q <= '0;
      else if (since_q != 10'h3FF) since_q <= since_q + 1'b1;
   end
   property p_spacing;
      @(posedge clock) disable iff (!resetn)
      adc_start && adc_channel != 2'h0 |-> since_q >= 10'd259;
   endproperty
   a_spacing: assert property (p_spacing)
      else $error("channel started too soon");
   property p_single_zero;
      @(posedge clock) disable iff (!resetn)
      method_q == M_SINGLE && !pub_q |->
         memory_block[63:60] == 4'h0 && memory_block[59:48] == 12'h000 &&
         memory_block[11:0] == 12'h000;
   endproperty
   a_single_zero: assert property (p_single_zero)
      else $error("single mode shows data before trigger");
   property p_seq;
      @(posedge clock) disable iff (!resetn)
      pend_q |=> memory_block[63:60] ==
         (($past(sn_q) == 4'hF) ? 4'h1 : $past(sn_q) + 4'h1);
   endproperty
   a_seq: assert property (p_seq)
      else $error("sequence number step wrong");
   property p_di;
      @(posedge clock) disable iff (!resetn)
      strap_done_q |=> memory_block[15:12] ==
         ($past(general_input_bits) ^ {4{inv_q}});
   endproperty
   a_di: assert property (p_di)
      else $error("input bits shown wrong");
   property p_status;
      @(posedge clock) disable iff (!resetn)
      $past(strap_done_q) |-> !memory_block[44] &&
         memory_block[47:46] == method_q && memory_block[28] == bip_q;
   endproperty
   a_status: assert property (p_status)
      else $error("status bits wrong");
   property p_join;
      @(posedge clock) disable iff (!resetn)
      avg_mode && !pub_q |-> !net_join;
   endproperty
   a_join: assert property (p_join)
      else $error("joined before first average");
   property p_reject;
      @(posedge clock) disable iff (!resetn)
      cfg_wr_valid && cfg_interval == 14'h2 && cfg_count_code == 2'h3
         |=> cfg_reject && ivl_q == $past(ivl_q);
   endproperty
   a_reject: assert property (p_reject)
      else $error("bad interval accepted");
   property p_defaults;
      @(posedge clock) disable iff (!resetn)
      !strap_done_q |-> ivl_q == 14'hA && cnt_q == 2'h2;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults wrong after reset");
   property p_hw_trig;
      @(posedge clock) disable iff (!resetn)
      method_q == M_SINGLE && !trg_q && !mode_q && strap_done_q &&
         st_q == S_IDLE && hw_fall |=> st_q == S_CONV ##[1:9] adc_start;
   endproperty
   a_hw_trig: assert property (p_hw_trig)
      else $error("hardware trigger ignored");
   property p_period;
      @(posedge clock) disable iff (!resetn)
      method_q == M_PERIOD && pend_q && !$past(cfg_hit) |-> fill_q == 5'h0;
   endproperty
   a_period: assert property (p_period)
      else $error("period set not restarted");
   c_pub: cover property (@(posedge clock) pend_q && avg_mode);
   c_wrap: cover property (@(posedge clock) pend_q && sn_q == 4'hF);
   c_cut: cover property (@(posedge clock) pend_q && cut_q && total == 5'd18);
endmodule

// >>> sim/nadc_adc_model.sv
// Purpose: converter stand-in that answers each adc_start with adc_done
// Assumes: one start at a time, as the sequencer promises
// Notes:   slow answers past the channel spacing so the done wait is used
`timescale 1ns/1ps
module nadc_adc_model (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        adc_start,
   input  wire logic [1:0]  adc_channel,
   input  wire logic        slow,
   input  wire logic [7:0]  lvl,
   output logic             adc_done,
   output logic      [11:0] adc_data
);
   int         cnt;
   logic [1:0] ch;
   logic       busy;
   always @(posedge clock) begin
      adc_done <= 1'b0;
      if (!resetn) begin
         busy <= 1'b0;
         cnt  <= 0;
         ch   <= 2'h0;
      end else if (adc_start) begin
         busy <= 1'b1;
         ch   <= adc_channel;
         cnt  <= slow ? 300 : 3;
      end else if (busy) begin
         if (cnt == 0) begin
            busy     <= 1'b0;
            adc_done <= 1'b1;
         end else begin
            cnt <= cnt - 1;
         end
      end
   end
   // outside the done cycle the data lines show a mangled word, never
   // the result, so a late sample cannot pass by luck
   assign adc_data = adc_done ? {ch, 2'b00, lvl} : {~ch, 2'b11, ~lvl};
endmodule

// >>> sim/tb_network_adc_sampler.sv
// Purpose: self-checking bench for nadc_sampler
// Assumes: UNIT_CYCLES of 10 keeps averaging intervals short
// Notes:   straps only latch at reset, so each method gets its own reset
`timescale 1ns/1ps
`include "nadc_consts.svh"
module tb_network_adc_sampler;
   logic        clock, resetn, mh_n, ml_n, inv_n, ncp, nwv, cwv, cts;
   logic        ccut, slow, adc_done, cfg_reject, adc_start, net_join, bip_n;
   logic [3:0]  di;
   logic [8:0]  nwa;
   logic [7:0]  lvl, nwd;
   logic [13:0] civl;
   logic [1:0]  ccnt, adc_channel, nxt;
   logic [11:0] adc_data;
   logic [63:0] mb;
   int          fail_count, checked, gap;
   always #50 clock = ~clock;
   nadc_sampler #(.UNIT_CYCLES(10)) i_nadc_sampler (
      .clock(clock), .resetn(resetn), .method_strap_high_n(mh_n),
      .method_strap_low_n(ml_n), .setting_mode_strap_n(1'b1),
      .inversion_strap_n(inv_n), .bipolar_strap_n(bip_n),
      .general_input_bits(di), .net_cycle_pulse(ncp),
      .net_wr_valid(nwv), .net_wr_addr(nwa), .net_wr_data(nwd),
      .cfg_wr_valid(cwv), .cfg_interval(civl), .cfg_count_code(ccnt),
      .cfg_trigger_source(cts), .cfg_extreme_cut(ccut),
      .cfg_hw_input_sel(2'h0), .cfg_watch_addr(9'h010),
      .cfg_watch_value(8'h55), .cfg_reject(cfg_reject),
      .adc_start(adc_start), .adc_channel(adc_channel),
      .adc_done(adc_done), .adc_data(adc_data), .net_join(net_join),
      .memory_block(mb));
   nadc_adc_model i_nadc_adc_model (
      .clock(clock), .resetn(resetn), .adc_start(adc_start),
      .adc_channel(adc_channel), .slow(slow), .lvl(lvl),
      .adc_done(adc_done), .adc_data(adc_data));
   task automatic chk(input string nm, input logic [63:0] e,
                      input logic [63:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   function automatic logic [63:0] blk(input logic [3:0] sn, hi, lo, d);
      logic [63:0] b;
      b = 64'h0;
      for (int c = 0; c < 4; c++) b[c*16 +: 12] = {c[1:0], 2'b00, lvl};
      b[15:12] = d;
      b[31:28] = lo;
      b[47:44] = hi;
      b[63:60] = sn;
      return b;
   endfunction
   task automatic rst(input logic h, l, v);
      @(negedge clock);
      resetn = 1'b0;
      mh_n = h;
      ml_n = l;
      inv_n = v;
      repeat (6) @(negedge clock);
      resetn = 1'b1;
      repeat (2) @(negedge clock);
   endtask
   task automatic wait_sn(input logic [3:0] sn);
      int i;
      for (i = 0; i < 9000 && mb[63:60] !== sn; i++) @(negedge clock);
      if (i == 9000) begin
         fail_count++;
         $display("unexpected sequence: expected %h seen %h", sn, mb[63:60]);
         close_out();
      end else begin
         // let the pass finish, a trigger during a pass is dropped
         repeat (300) @(negedge clock);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clock);
      s = 1'b1;
      @(negedge clock);
      s = 1'b0;
   endtask
   task automatic cfg(input logic [13:0] iv, input logic [1:0] cn,
                      input logic cut, sw, rej);
      @(negedge clock);
      cwv = 1'b1;
      civl = iv;
      ccnt = cn;
      ccut = cut;
      cts = sw;
      @(negedge clock);
      cwv = 1'b0;
      chk("cfg_reject", {63'h0, rej}, {63'h0, cfg_reject});
   endtask
   // channel order and minimum spacing between starts of one pass
   always @(posedge clock) begin
      gap <= gap + 1;
      if (!resetn) nxt <= 2'h0;
      else if (adc_start === 1'b1) begin
         chk("adc_channel", {62'h0, nxt}, {62'h0, adc_channel});
         if (nxt != 2'h0) begin
            chk("gap", 64'h1, {63'h0, gap >= `NADC_SPACING_CYC});
         end
         nxt <= nxt + 2'h1;
         gap <= 1;
      end
   end
   initial begin
      {clock, resetn, ncp, nwv, cwv, cts, ccut, slow} = 8'h0;
      {mh_n, ml_n, inv_n, bip_n} = 4'hF;
      nwd = 8'h55;
      {ccnt, civl, nwa} = 25'h0;
      {fail_count, checked} = {32'h0, 32'h0};
      di = 4'hA;
      lvl = 8'h21;
      rst(1'b1, 1'b1, 1'b1);
      chk("net_join", 64'h1, {63'h0, net_join});
      pulse(ncp);
      wait_sn(4'h1);
      chk("block", blk(4'h1, 4'h0, 4'h0, 4'hA), mb);
      for (int k = 2; k <= 16; k++) begin
         pulse(ncp);
         wait_sn(k[3:0] == 4'h0 ? 4'h1 : k[3:0]);
      end
      chk("block", blk(4'h1, 4'h0, 4'h0, 4'hA), mb);
      cfg(14'h0001, 2'h0, 1'b0, 1'b0, 1'b1);
      cfg(14'h2711, 2'h0, 1'b0, 1'b0, 1'b1);
      cfg(14'h0002, 2'h3, 1'b0, 1'b0, 1'b1);
      cfg(14'h0002, 2'h2, 1'b1, 1'b0, 1'b1);
      cfg(14'h0002, 2'h2, 1'b0, 1'b0, 1'b0);
      cfg(14'h2710, 2'h3, 1'b1, 1'b0, 1'b0);
      di = 4'h0;
      lvl = 8'h3C;
      rst(1'b1, 1'b0, 1'b0);
      chk("zero", 64'h0, mb & 64'hFFFF_0FFF_0FFF_0FFF);
      chk("status", 64'h0000_4000_4000_F000,
          mb & 64'h0000_F000_F000_F000);
      @(negedge clock);
      di = 4'h1;
      wait_sn(4'h1);
      chk("block", blk(4'h1, 4'h4, 4'h4, 4'hE), mb);
      cfg(14'h000A, 2'h0, 1'b0, 1'b1, 1'b0);
      nwa = 9'h011;
      pulse(nwv);
      nwa = 9'h010;
      pulse(nwv);
      wait_sn(4'h2);
      chk("block", blk(4'h2, 4'h4, 4'hC, 4'hE), mb);
      di = 4'h5;
      rst(1'b0, 1'b1, 1'b1);
      slow = 1'b1;
      cfg(14'h00C8, 2'h0, 1'b0, 1'b0, 1'b0);
      chk("net_join", 64'h0, {63'h0, net_join});
      wait_sn(4'h1);
      chk("block", blk(4'h1, 4'h8, 4'h0, 4'h5), mb);
      chk("net_join", 64'h1, {63'h0, net_join});
      bip_n = 1'b0;
      slow = 1'b0;
      rst(1'b0, 1'b0, 1'b1);
      cfg(14'h0002, 2'h0, 1'b1, 1'b0, 1'b0);
      chk("net_join", 64'h0, {63'h0, net_join});
      wait_sn(4'h1);
      chk("block", blk(4'h1, 4'hC, 4'h3, 4'h5), mb);
      wait_sn(4'h2);
      chk("block", blk(4'h2, 4'hC, 4'h3, 4'h5), mb);
      close_out();
   end
endmodule
